// [dv/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                           i_clock = 1'b0;
  logic                           i_sys_rst = 1'b1;
  logic [tpg_pkg::REG_ADDR_W-1:0] i_reg_addr = '0;
  logic [31:0]                    i_reg_wdata = '0;
  logic                           i_reg_write = 1'b0;
  logic                           i_reg_read = 1'b0;
  logic [31:0]                    o_reg_rdata;
  logic                           stall = 1'b0;
  logic                           rel = 1'b0;
  logic [7:0]                     bad = 8'hff;
  logic                           af, we, re, empty, active, fail;
  logic [511:0]                   txd, rxd;
  logic [2:0]                     pat;
  logic [47:0]                    base;
  int                             idx, endc;
  int                             miscompares = 0;
  int                             total_checks = 0;

  always #4 i_clock = ~i_clock;
  always @(posedge i_clock) stall <= ($urandom % 4) == 0;

  tpg_test_gen u_dut (.i_clock, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata,
    .i_tx_fifo_almost_full(af), .o_tx_fifo_write_enable(we), .o_tx_fifo_data(txd), .i_rx_fifo_empty(empty),
    .o_rx_fifo_read_enable(re), .i_rx_fifo_data(rxd), .o_write_transfer_active(active), .o_fail(fail));
  tpg_fifo_model u_far (.i_clock, .i_stall(stall), .i_release(rel), .i_bad_word(bad), .i_we(we), .i_wdata(txd),
    .i_re(re), .o_almost_full(af), .o_empty(empty), .o_rdata(rxd));

  task automatic finish_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [511:0] exp, input logic [511:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [511:0] expect_word(logic [2:0] p, logic [47:0] a, logic [2:0] b);
    logic [511:0] w;
    logic [31:0]  s;
    for (int d = 0; d < 16; d++)
    begin
      s = 32'({~a[31:0], a[31:0]} >> (8 * (d % 4)));
      repeat (4 * b + d / 4) s = {s[30:0], s[30] ^ s[20] ^ s[0]};
      case (p)
        tpg_pkg::PATT_ONE:  w[32*d +: 32] = '1;
        tpg_pkg::PATT_INC:  w[32*d +: 32] = {a[24:0], b, d[3:0]};
        tpg_pkg::PATT_DEC:  w[32*d +: 32] = ~{a[24:0], b, d[3:0]};
        tpg_pkg::PATT_LFSR: w[32*d +: 32] = s;
        default:            w[32*d +: 32] = '0;
      endcase
    end
    if (p > 3'h1 && b == 3'h0)
      w[63:0] = {16'h0, a};
    return w;
  endfunction : expect_word

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_clock);
    i_reg_write <= 1'b0;
  endtask : reg_wr

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    #1 check(what, 512'(exp), 512'(o_reg_rdata));
  endtask : reg_chk

  // Bounded wait for the write run to end or the read side to drain
  task automatic wait_done(input bit rd);
    int k;
    for (k = 0; k < 3000 && (rd ? empty !== 1'b1 : active !== 1'b0); k++)
      @(posedge i_clock);
    if (k == 3000)
    begin
      $display("Error wait expected idle seen busy");
      miscompares++;
      finish_test();
    end
  endtask : wait_done

  always @(posedge i_clock)
    if (we === 1'b1)
    begin
      check("tx word", expect_word(pat, base + 48'(idx / 8), 3'(idx % 8)), txd);
      idx++;
    end

  initial
  begin
    void'($urandom(67169));
    repeat (4) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    reg_chk(tpg_pkg::REG_STATUS, 32'h0, "status");
    reg_chk(8'h3c, 32'h0, "unmapped");
    for (int p = 0; p < 5; p++)
    begin
      pat = 3'(p);
      base = {16'($urandom), 32'hffff_fffe};
      endc = 9 + $urandom % 16;
      bad = (p == 4) ? 8'h05 : 8'hff;
      idx = 0;
      reg_wr(tpg_pkg::REG_PATTERN, 32'(p));
      reg_wr(tpg_pkg::REG_START_LO, base[31:0]);
      reg_wr(tpg_pkg::REG_START_HI, 32'(base[47:32]));
      reg_wr(tpg_pkg::REG_END_LO, 32'(endc));
      reg_wr(tpg_pkg::REG_END_HI, 32'h0);
      reg_wr(tpg_pkg::REG_CONTROL, 32'h1);
      repeat (4) @(posedge i_clock);
      wait_done(1'b0);
      check("word count", 512'(endc), 512'(idx));
      reg_chk(tpg_pkg::REG_COUNT_LO, 32'(endc), "count reg");
      reg_chk(tpg_pkg::REG_BLOCK_LO, base[31:0] + 32'(endc / 8), "block reg");
      reg_wr(tpg_pkg::REG_CONTROL, 32'h7);
      rel <= 1'b1;
      repeat (2) @(posedge i_clock);
      wait_done(1'b1);
      repeat (4) @(posedge i_clock);
      check("fail flag", 512'(p == 4), 512'(fail));
      reg_chk(tpg_pkg::REG_COUNT_LO, 32'(endc), "read count");
      reg_chk(tpg_pkg::REG_BLOCK_LO, base[31:0] + 32'(endc / 8), "read block");
      rel <= 1'b0;
    end
    finish_test();
  end
endmodule : tb

// [dv/tpg_fifo_model.sv]
module tpg_fifo_model
(
  input  wire logic                       i_clock,
  input  wire logic                       i_stall,
  input  wire logic                       i_release,
  input  wire logic [7:0]                 i_bad_word,
  input  wire logic                       i_we,
  input  wire logic [tpg_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_re,
  output logic                            o_almost_full,
  output logic                            o_empty,
  output logic      [tpg_pkg::DATA_W-1:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [tpg_pkg::DATA_W-1:0] store[$];
  int                         fill = 0;
  int                         pops = 0;

  initial o_rdata = '0;
  assign o_almost_full = i_stall;
  // Data is held back from the read side until the bench releases it
  assign o_empty = !i_release || fill == 0;

  always @(posedge i_clock)
  begin
    if (i_we)
      store.push_back(i_wdata);
    if (!i_release)
      pops = 0;
    if (i_re && i_release && store.size() > 0)
    begin
      o_rdata <= store.pop_front() ^ {511'h0, pops == i_bad_word};
      pops++;
    end
    else
      o_rdata <= ~o_rdata;
    fill <= store.size();
  end
endmodule : tpg_fifo_model

// [dv/tpg_props.sv]
module tpg_props
(
  input wire logic                           i_clock,
  input wire logic                           i_sys_rst,
  input wire logic [tpg_pkg::REG_ADDR_W-1:0] i_reg_addr,
  input wire logic [31:0]                    i_reg_wdata,
  input wire logic                           i_reg_write,
  input wire logic                           i_tx_fifo_almost_full,
  input wire logic                           o_tx_fifo_write_enable,
  input wire logic [tpg_pkg::DATA_W-1:0]     o_tx_fifo_data,
  input wire logic                           i_rx_fifo_empty,
  input wire logic                           o_rx_fifo_read_enable,
  input wire logic                           o_write_transfer_active,
  input wire logic                           o_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic start_wr;

  assign start_wr = i_reg_write && i_reg_addr == tpg_pkg::REG_CONTROL && i_reg_wdata[tpg_pkg::CTRL_START_BIT];

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence write_launch;
    start_wr && !i_reg_wdata[tpg_pkg::CTRL_READ_BIT];
  endsequence

  sequence run_up;
    ##2 o_write_transfer_active;
  endsequence

  start_active_a:
    assert property (write_launch |-> run_up) else $error("start did not raise active");
  active_cause_a:
    assert property ($rose(o_write_transfer_active) |-> $past(start_wr, 2)) else $error("active without start");
  we_room_a:
    assert property (o_tx_fifo_write_enable |-> o_write_transfer_active && $past(!i_tx_fifo_almost_full))
      else $error("write enable without room");
  hold_data_a:
    assert property (o_write_transfer_active && $past(o_write_transfer_active) && !o_tx_fifo_write_enable
      |-> $stable(o_tx_fifo_data)) else $error("paused data moved");
  end_fall_a:
    assert property ($fell(o_write_transfer_active) |-> $past(o_tx_fifo_write_enable) && !o_tx_fifo_write_enable)
      else $error("active and enable did not stop together");
  read_cause_a:
    assert property (o_rx_fifo_read_enable |-> $past(!i_rx_fifo_empty)) else $error("read while empty");
  fail_cause_a:
    assert property ($rose(o_fail) |-> $past(o_rx_fifo_read_enable, 2)) else $error("fail without read");
  fail_sticky_a:
    assert property (o_fail && !$past(start_wr) |=> o_fail) else $error("fail flag dropped");
endmodule : tpg_props

bind tpg_test_gen tpg_props u_props (.i_clock, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_write,
  .i_tx_fifo_almost_full, .o_tx_fifo_write_enable, .o_tx_fifo_data, .i_rx_fifo_empty, .o_rx_fifo_read_enable,
  .o_write_transfer_active, .o_fail);

// [verilog/tpg_pattern_gen.sv]
module tpg_pattern_gen
(
  input  wire logic [tpg_pkg::ADDR_W-1:0] i_header_block_address,
  input  wire logic [tpg_pkg::BEAT_W-1:0] i_beat,
  input  wire logic [2:0]                 i_pattern_sel,
  input  wire logic [tpg_pkg::LFSR_W-1:0] i_lfsr_state,
  output logic      [tpg_pkg::DATA_W-1:0] o_pattern_word,
  output logic      [tpg_pkg::LFSR_W-1:0] o_lfsr_last
);

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    lfsr_step = {s[30:0], s[30] ^ s[20] ^ s[0]};
  endfunction : lfsr_step

  logic [31:0] seed_block_address;
  logic [31:0] seed_block_address_inverted;
  logic [31:0] seed [4];
  logic [31:0] pattern_word [16];
  logic [54:0] dword_index;

  always_comb
  begin
    seed_block_address          = i_header_block_address[31:0];
    seed_block_address_inverted = ~i_header_block_address[31:0];
    // Four sets seeded from address and its inverse
    seed[0] = seed_block_address;
    seed[1] = {seed_block_address_inverted[7:0], seed_block_address[31:8]};
    seed[2] = {seed_block_address_inverted[15:0], seed_block_address[31:16]};
    seed[3] = {seed_block_address_inverted[23:0], seed_block_address[31:24]};
    o_pattern_word = '0;
    o_lfsr_last    = '0;
    dword_index    = '0;
    for (int j = 0; j < 4; j++)
    begin
      // Each set advances four steps per beat by look-ahead
      pattern_word[j]      = (i_beat == '0) ? seed[j] : lfsr_step(i_lfsr_state[j*32 +: 32]);
      pattern_word[j + 4]  = lfsr_step(pattern_word[j]);
      pattern_word[j + 8]  = lfsr_step(pattern_word[j + 4]);
      pattern_word[j + 12] = lfsr_step(pattern_word[j + 8]);
      o_lfsr_last[j*32 +: 32] = pattern_word[j + 12];
    end
    for (int k = 0; k < 16; k++)
    begin
      dword_index = {i_header_block_address, i_beat, 4'(k)};
      case (i_pattern_sel)
        tpg_pkg::PATT_ZERO: o_pattern_word[k*32 +: 32] = 32'h0000_0000;
        tpg_pkg::PATT_ONE:  o_pattern_word[k*32 +: 32] = 32'hffff_ffff;
        tpg_pkg::PATT_INC:  o_pattern_word[k*32 +: 32] = dword_index[31:0];
        tpg_pkg::PATT_DEC:  o_pattern_word[k*32 +: 32] = ~dword_index[31:0];
        tpg_pkg::PATT_LFSR: o_pattern_word[k*32 +: 32] = pattern_word[k];
        default:            o_pattern_word[k*32 +: 32] = 32'h0000_0000;
      endcase
    end
    // Header on first two dwords of each block for every pattern except zero and ones
    if ((i_beat == '0) && (i_pattern_sel != tpg_pkg::PATT_ZERO) && (i_pattern_sel != tpg_pkg::PATT_ONE))
    begin
      o_pattern_word[31:0]  = i_header_block_address[31:0];
      o_pattern_word[63:32] = {16'h0000, i_header_block_address[47:32]};
    end
  end

endmodule : tpg_pattern_gen

// [verilog/tpg_pkg.sv]
package tpg_pkg;

  localparam int DATA_W       = 512;
  localparam int DWORD_W      = 32;
  localparam int ADDR_W       = 48;
  localparam int BEAT_W       = 3;
  localparam int LFSR_SETS    = 4;
  localparam int LFSR_W       = LFSR_SETS * DWORD_W;
  localparam int REG_ADDR_W   = 8;

  localparam logic [BEAT_W-1:0] LAST_BEAT = 3'h7;

  localparam logic [REG_ADDR_W-1:0] REG_CONTROL      = 8'h00;
  localparam logic [REG_ADDR_W-1:0] REG_PATTERN      = 8'h04;
  localparam logic [REG_ADDR_W-1:0] REG_START_LO     = 8'h08;
  localparam logic [REG_ADDR_W-1:0] REG_START_HI     = 8'h0c;
  localparam logic [REG_ADDR_W-1:0] REG_END_LO       = 8'h10;
  localparam logic [REG_ADDR_W-1:0] REG_END_HI       = 8'h14;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS       = 8'h18;
  localparam logic [REG_ADDR_W-1:0] REG_COUNT_LO     = 8'h1c;
  localparam logic [REG_ADDR_W-1:0] REG_COUNT_HI     = 8'h20;
  localparam logic [REG_ADDR_W-1:0] REG_BLOCK_LO     = 8'h24;
  localparam logic [REG_ADDR_W-1:0] REG_BLOCK_HI     = 8'h28;

  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_READ_BIT   = 1;
  localparam int CTRL_VERIFY_BIT = 2;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_FAIL_BIT   = 1;
  localparam int STAT_READ_BIT   = 2;

  localparam logic [2:0] PATT_ZERO = 3'h0;
  localparam logic [2:0] PATT_ONE  = 3'h1;
  localparam logic [2:0] PATT_INC  = 3'h2;
  localparam logic [2:0] PATT_DEC  = 3'h3;
  localparam logic [2:0] PATT_LFSR = 3'h4;

  typedef enum logic [1:0]
  {
    TPG_IDLE  = 2'b01,
    TPG_WRITE = 2'b10
  } tpg_fsm_t;

  typedef struct packed
  {
    logic [31:0]           wdata;
    logic [REG_ADDR_W-1:0] addr;
    logic                  wr;
    logic                  rd;
  } tpg_reg_req_t;

  typedef struct packed
  {
    tpg_fsm_t              fsm;
    logic                  start_pulse;
    logic                  tx_we;
    logic [DATA_W-1:0]     tx_data;
    logic                  rx_re;
    logic                  cmp_valid;
    logic [DATA_W-1:0]     expected;
    logic                  fail;
    logic                  verify_en;
    logic                  read_mode;
    logic [2:0]            pattern_sel;
    logic [ADDR_W-1:0]     start_addr;
    logic [ADDR_W-1:0]     end_count;
    logic [ADDR_W-1:0]     word_count;
    logic [ADDR_W-1:0]     block_addr;
    logic [BEAT_W-1:0]     beat;
    logic [LFSR_W-1:0]     lfsr;
    logic [31:0]           rdata;
  } tpg_state_t;

endpackage : tpg_pkg

// [verilog/tpg_test_gen.sv]
module tpg_test_gen
(
  input  wire logic                                 i_clock,
  input  wire logic                                 i_sys_rst,
  input  wire logic [tpg_pkg::REG_ADDR_W-1:0]       i_reg_addr,
  input  wire logic [31:0]                          i_reg_wdata,
  input  wire logic                                 i_reg_write,
  input  wire logic                                 i_reg_read,
  output logic      [31:0]                          o_reg_rdata,
  input  wire logic                                 i_tx_fifo_almost_full,
  output logic                                      o_tx_fifo_write_enable,
  output logic      [tpg_pkg::DATA_W-1:0]           o_tx_fifo_data,
  input  wire logic                                 i_rx_fifo_empty,
  output logic                                      o_rx_fifo_read_enable,
  input  wire logic [tpg_pkg::DATA_W-1:0]           i_rx_fifo_data,
  output logic                                      o_write_transfer_active,
  output logic                                      o_fail
);

  tpg_pkg::tpg_state_t   r;
  tpg_pkg::tpg_state_t   next_r;
  tpg_pkg::tpg_reg_req_t req;
  logic [tpg_pkg::DATA_W-1:0] gen_word;
  logic [tpg_pkg::LFSR_W-1:0] gen_lfsr_last;
  logic                       write_transfer_active;
  logic                       advance;
  logic                       mismatch;
  logic                       rx_take;

  function automatic logic [31:0] read_value(input tpg_pkg::tpg_state_t s, input logic [7:0] a);
    case (a)
      tpg_pkg::REG_CONTROL:  read_value = {29'h0, s.verify_en, s.read_mode, 1'b0};
      tpg_pkg::REG_PATTERN:  read_value = {29'h0, s.pattern_sel};
      tpg_pkg::REG_START_LO: read_value = s.start_addr[31:0];
      tpg_pkg::REG_START_HI: read_value = {16'h0, s.start_addr[47:32]};
      tpg_pkg::REG_END_LO:   read_value = s.end_count[31:0];
      tpg_pkg::REG_END_HI:   read_value = {16'h0, s.end_count[47:32]};
      tpg_pkg::REG_STATUS:   read_value = {29'h0, s.read_mode, s.fail, (s.fsm == tpg_pkg::TPG_WRITE)};
      tpg_pkg::REG_COUNT_LO: read_value = s.word_count[31:0];
      tpg_pkg::REG_COUNT_HI: read_value = {16'h0, s.word_count[47:32]};
      tpg_pkg::REG_BLOCK_LO: read_value = s.block_addr[31:0];
      tpg_pkg::REG_BLOCK_HI: read_value = {16'h0, s.block_addr[47:32]};
      default:               read_value = 32'h0000_0000;
    endcase
  endfunction : read_value

  assign req.addr  = i_reg_addr;
  assign req.wdata = i_reg_wdata;
  assign req.wr    = i_reg_write;
  assign req.rd    = i_reg_read;

  // One-hot bit of the write state, so the flag comes straight from a flop
  assign write_transfer_active = r.fsm[1];

  // Shared generator for write data and expected read data
  tpg_pattern_gen u_pattern
  (
    .i_header_block_address (r.block_addr),
    .i_beat                 (r.beat),
    .i_pattern_sel          (r.pattern_sel),
    .i_lfsr_state           (r.lfsr),
    .o_pattern_word         (gen_word),
    .o_lfsr_last            (gen_lfsr_last)
  );

  assign mismatch = r.cmp_valid && (i_rx_fifo_data != r.expected);

  // A read is taken only if the FIFO still held data when it sampled the enable
  assign rx_take = r.rx_re && !i_rx_fifo_empty;

  always_comb
  begin
    next_r       = r;
    advance      = 1'b0;
    next_r.rdata = 32'h0000_0000;
    next_r.start_pulse = 1'b0;

    if (req.rd)
    begin
      next_r.rdata = read_value(r, req.addr);
    end

    if (req.wr)
    begin
      case (req.addr)
        tpg_pkg::REG_CONTROL:
        begin
          next_r.start_pulse = req.wdata[tpg_pkg::CTRL_START_BIT];
          next_r.read_mode   = req.wdata[tpg_pkg::CTRL_READ_BIT];
          next_r.verify_en   = req.wdata[tpg_pkg::CTRL_VERIFY_BIT];
        end
        tpg_pkg::REG_PATTERN:  next_r.pattern_sel = req.wdata[2:0];
        tpg_pkg::REG_START_LO: next_r.start_addr[31:0] = req.wdata;
        tpg_pkg::REG_START_HI: next_r.start_addr[47:32] = req.wdata[15:0];
        tpg_pkg::REG_END_LO:   next_r.end_count[31:0] = req.wdata;
        tpg_pkg::REG_END_HI:   next_r.end_count[47:32] = req.wdata[15:0];
        default:               next_r.rdata = next_r.rdata;
      endcase
    end

    // Write side
    next_r.tx_we = 1'b0;
    case (r.fsm)
      tpg_pkg::TPG_IDLE:
      begin
        if (r.start_pulse && !r.read_mode)
        begin
          next_r.fsm = tpg_pkg::TPG_WRITE;
        end
      end
      tpg_pkg::TPG_WRITE:
      begin
        if (r.word_count == r.end_count)
        begin
          next_r.fsm = tpg_pkg::TPG_IDLE;
        end
        else
        begin
          next_r.tx_we = !i_tx_fifo_almost_full;
        end
      end
      default:
      begin
        next_r.fsm = tpg_pkg::TPG_IDLE;
      end
    endcase

    // Read side runs free in read mode
    next_r.rx_re = r.read_mode && !i_rx_fifo_empty;

    // Expected word is latched with the taken read so it lines up with the popped data
    advance = next_r.tx_we || rx_take;
    if (next_r.tx_we)
    begin
      next_r.tx_data = gen_word;
    end
    if (rx_take)
    begin
      next_r.expected = gen_word;
    end
    next_r.cmp_valid = rx_take;

    if (advance)
    begin
      next_r.word_count = r.word_count + 48'h1;
      next_r.beat       = r.beat + 3'h1;
      next_r.lfsr       = gen_lfsr_last;
      if (r.beat == tpg_pkg::LAST_BEAT)
      begin
        next_r.block_addr = r.block_addr + 48'h1;
      end
    end

    if (r.start_pulse)
    begin
      next_r.block_addr = r.start_addr;
      next_r.beat       = '0;
      next_r.word_count = '0;
      next_r.fail       = 1'b0;
      next_r.tx_we      = 1'b0;
      next_r.rx_re      = 1'b0;
    end

    // Set wins over the clear from a new start
    if (mismatch && r.verify_en)
    begin
      next_r.fail = 1'b1;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      r     <= '0;
      r.fsm <= tpg_pkg::TPG_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_reg_rdata             = r.rdata;
  assign o_tx_fifo_write_enable  = r.tx_we;
  assign o_tx_fifo_data          = r.tx_data;
  assign o_rx_fifo_read_enable   = r.rx_re;
  assign o_write_transfer_active = write_transfer_active;
  assign o_fail                  = r.fail;

endmodule : tpg_test_gen
